// File: tb/adcsrc_top_tb.sv
// self-checking bench for the sequence/result control block
`timescale 1ns/1ps
module adcsrc_top_tb;
  localparam int RW = 12;
  localparam logic [1:0] OK = adcsrc_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = adcsrc_pkg::RESP_SLVERR;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, cd, cd2;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, conv_done = 1'b0;
  logic freeze_req = 1'b0, compare_irq_enable = 1'b0;
  logic [15:0] per_result_compare_enable = 16'h0000, cmp_en_out;
  logic [16:0] prev_en = 17'h0_0000;
  logic [RW-1:0] conv_data = '0;
  logic awready, wready, bvalid, arready, rvalid;
  logic conv_start, conv_abort, conv_freeze, cmp_irq_en_out;
  logic [1:0] bresp, rresp;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  logic [RW-1:0] clog[$];
  logic [33:0] e;
  logic [31:0] seed = 32'h0000_0055;
  int err_count = 0, comparisons = 0;
  int owed = 0, budget = 0, dly = 0, abort_cnt = 0, a0;

  // --------------------------------------------------
  // clock, design, random source
  // --------------------------------------------------
  always #10 aclk = ~aclk;

  adcsrc_top #(.RES_W(RW)) adcsrc_top_i (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .conv_start(conv_start), .conv_abort(conv_abort),
    .conv_freeze(conv_freeze), .conv_done(conv_done),
    .conv_data(conv_data), .freeze_req(freeze_req),
    .compare_irq_enable(compare_irq_enable),
    .per_result_compare_enable(per_result_compare_enable),
    .cmp_irq_en_out(cmp_irq_en_out), .cmp_en_out(cmp_en_out));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // --------------------------------------------------
  // reporting
  // --------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  // hang guard, well past the few hundred cycles the tests need
  initial begin
    #400000;
    err_count++;
    finish_test();
  end

  // --------------------------------------------------
  // core stand-in: one answer per start, random delay
  // --------------------------------------------------
  // budget lets a test hold answers back to stall the core
  always @(posedge aclk) begin
    conv_done <= 1'b0;
    if (conv_abort) abort_cnt++;
    if (conv_start) owed++;
    if (dly > 0) dly--;
    else if (owed > 0 && budget > 0) begin
      cd = rnd();
      conv_data <= cd[RW-1:0];
      clog.push_back(cd[RW-1:0]);
      conv_done <= 1'b1;
      owed--;
      budget--;
      dly = int'(cd[17:16]);
    end
  end

  // compare enables change every cycle so a stale copy shows
  always @(posedge aclk) begin
    cd2 = rnd();
    per_result_compare_enable <= cd2[15:0];
    compare_irq_enable <= cd2[16];
    prev_en <= {compare_irq_enable, per_result_compare_enable};
  end

  // --------------------------------------------------
  // result watcher: oldest note against each response
  // --------------------------------------------------
  always @(posedge aclk) begin
    if (bvalid && bready) check({30'h0, bresp}, {30'h0, bq.pop_front()});
    if (rvalid && rready) begin
      e = rq.pop_front();
      check(rdata, e[31:0]);
      check({30'h0, rresp}, {30'h0, e[33:32]});
    end
  end

  // --------------------------------------------------
  // bus tasks
  // --------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    bit aw_ok, w_ok;
    bq.push_back(r);
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    @(posedge aclk); // idle edge: next call must not re-raise bready now
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    rq.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    @(posedge aclk); // idle edge: next call must not re-raise rready now
  endtask : axi_rd

  // start a sequence and let the core answer n times
  task automatic run(input logic [31:0] sd, input int n);
    clog.delete();
    budget = n;
    axi_wr(8'h14, sd, OK);
    wait (budget == 0);
    repeat (3) @(posedge aclk);
  endtask : run

  task automatic cmp_chk(input bit fifo);
    @(negedge aclk);
    check({15'h0, cmp_irq_en_out, cmp_en_out},
          fifo ? 32'h0 : {15'h0, prev_en});
  endtask : cmp_chk

  // --------------------------------------------------
  // main sequence
  // --------------------------------------------------
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(8'h0C, 32'h0000_0020, OK);
    axi_rd(8'h18, 32'h0000_0000, OK);
    axi_rd(8'h3C, 32'h0000_0000, ERR);
    axi_wr(8'h3C, 32'h0000_00FF, ERR);
    $display("test reset and map done");
    // left justify, length two, debugger halt ignored with code 00
    freeze_req <= 1'b1;
    axi_wr(8'h0C, 32'h0000_0010, OK);
    cmp_chk(1'b0);
    run(32'h0000_0000, 2);
    axi_rd(8'h40, 32'(clog[0]) << (16 - RW), OK);
    axi_rd(8'h44, 32'(clog[1]) << (16 - RW), OK);
    axi_rd(8'h18, 32'h0000_0000, OK);
    axi_rd(8'h20, 32'h0000_0003, OK);
    axi_wr(8'h20, 32'h0000_0001, OK);
    axi_rd(8'h20, 32'h0000_0002, OK);
    freeze_req <= 1'b0;
    $display("test left justify done");
    // right justify, zero length field means sixteen
    axi_wr(8'h0C, 32'h0000_0080, OK);
    run(32'h0000_0000, 16);
    for (int i = 0; i < 16; i++) begin
      axi_rd(8'h40 + 8'(4 * i), 32'(clog[i]), OK);
    end
    axi_rd(8'h20, 32'h0000_FFFF, OK);
    $display("test right justify done");
    // fifo placement, length three
    axi_wr(8'h0C, 32'h0000_009C, OK);
    axi_rd(8'h0C, 32'h0000_009C, OK);
    cmp_chk(1'b1);
    run(32'h0000_0000, 3);
    axi_rd(8'h18, 32'h0000_0003, OK);
    axi_rd(8'h48, 32'(clog[2]), OK);
    run(32'h0000_0000, 3);
    axi_rd(8'h40, 32'(clog[0]), OK);
    axi_rd(8'h18, 32'h0000_0003, OK);
    $display("test fifo done");
    // fifo scan: eighteen results wrap the counter to two
    run(32'h0000_0020, 18);
    axi_rd(8'h18, 32'h0000_0082, OK);
    axi_rd(8'h44, 32'(clog[17]), OK);
    a0 = abort_cnt;
    axi_wr(8'h0C, 32'h0000_009C, OK);
    repeat (2) @(posedge aclk);
    check(32'(abort_cnt), 32'(a0 + 1));
    budget = 1;
    repeat (8) @(posedge aclk);
    axi_rd(8'h18, 32'h0000_0000, OK);
    $display("test fifo scan and abort done");
    // pause now: core waits while the debugger holds
    axi_wr(8'h0C, 32'h0000_000B, OK);
    clog.delete();
    axi_wr(8'h14, 32'h0000_0000, OK);
    repeat (4) @(posedge aclk);
    freeze_req <= 1'b1;
    repeat (2) @(posedge aclk);
    check({31'h0, conv_freeze}, 32'h1);
    freeze_req <= 1'b0;
    budget = 1;
    wait (budget == 0);
    repeat (3) @(posedge aclk);
    check({31'h0, conv_freeze}, 32'h0);
    axi_rd(8'h40, 32'(clog[0]) << (16 - RW), OK);
    // finish-then-hold: a start under freeze waits with no core request
    axi_wr(8'h0C, 32'h0000_000A, OK);
    freeze_req <= 1'b1;
    clog.delete();
    axi_wr(8'h14, 32'h0000_0000, OK);
    repeat (4) @(posedge aclk);
    check(32'(owed), 32'h0000_0000);
    axi_rd(8'h18, 32'h0000_0080, OK);
    freeze_req <= 1'b0;
    budget = 1;
    wait (budget == 0);
    repeat (3) @(posedge aclk);
    axi_rd(8'h40, 32'(clog[0]) << (16 - RW), OK);
    $display("test freeze done");
    finish_test();
  end
endmodule : adcsrc_top_tb

// File: verilog/adcsrc_axil_slave.sv
// axi4-lite slave front end: one write and one read in flight
`timescale 1ns/1ps
module adcsrc_axil_slave #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address and data
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read channels
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // register side
  output logic wr_fire,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);

  logic aw_have;
  logic w_have;

  // address and data may arrive in either order
  assign awready = !aw_have;
  assign wready = !w_have;
  assign wr_fire = aw_have && w_have && !bvalid;
  assign arready = !rvalid;
  assign rd_addr = araddr;

  // write address holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      wr_addr <= '0;
    end else if (awvalid && awready) begin
      aw_have <= 1'b1;
      wr_addr <= awaddr;
    end else if (wr_fire) begin
      aw_have <= 1'b0;
    end
  end

  // write data holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have <= 1'b0;
      wr_data <= '0;
      wr_strb <= '0;
    end else if (wvalid && wready) begin
      w_have <= 1'b1;
      wr_data <= wdata;
      wr_strb <= wstrb;
    end else if (wr_fire) begin
      w_have <= 1'b0;
    end
  end

  // response follows the register write by one edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= adcsrc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp <= wr_ok ? adcsrc_pkg::RESP_OKAY : adcsrc_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // read data is captured at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= adcsrc_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rd_ok ? rd_data : 32'h0000_0000;
      rresp <= rd_ok ? adcsrc_pkg::RESP_OKAY : adcsrc_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule : adcsrc_axil_slave

// File: verilog/adcsrc_conv_counter.sv
// conversion counter: result register index for the next result
`timescale 1ns/1ps
module adcsrc_conv_counter #(
  parameter int CNT_W = 4
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic clr,
  input wire logic adv,
  input wire logic seq_wrap,
  // count
  output logic [CNT_W-1:0] cnt
);

  // a zero-width counter cannot index the result file
  generate
    if (CNT_W < 1) begin : g_bad_width
      $error("CNT_W must be at least 1");
    end
  endgenerate

  // clear beats advance; natural overflow wraps the result file
  always_ff @(posedge aclk) begin
    if (!aresetn || clr) begin
      cnt <= '0;
    end else if (adv) begin
      if (seq_wrap) begin
        cnt <= '0;
      end else begin
        cnt <= CNT_W'(cnt + 1'b1);
      end
    end
  end

endmodule : adcsrc_conv_counter

// File: verilog/adcsrc_pkg.sv
// constants and types for the converter sequence/result control block
//
// Overview of operation
// - any write to byte lane 0 of sequence_result_control aborts the running sequence
// - bit 7 picks left (0) or right (1) justified unsigned results
// - bits 6..3 give conversions per sequence; reset value gives four
// - with bit 2 clear, result n goes to result register n
// - fifo placement keeps the counter across sequence end; a start write clears it
// - fifo counter wraps to result register 0 after the last one
// - status register shows the 4-bit conversion counter
// - abort or start write clears the counter, fifo mode too
// - fifo placement forces all compare enables to zero
// - bits 1..0 pick the response to a debugger freeze
// - per-result complete flags show which results hold valid data
package adcsrc_pkg;

  // ----------------------------------------
  // register indices, byte address is 4x
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [5:0] CTL3_IDX = 6'h03;
  localparam logic [5:0] START_IDX = 6'h05;
  localparam logic [5:0] STAT0_IDX = 6'h06;
  localparam logic [5:0] FLAGS_IDX = 6'h08;
  localparam logic [5:0] RES_BASE_IDX = 6'h10;

  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam logic [7:0] CTL3_RST = 8'h20;
  localparam int JUSTIFY_BIT = 7;
  localparam int SEQ_LEN_LSB = 3;
  localparam int FIFO_BIT = 2;
  localparam int FREEZE_LSB = 0;
  localparam int SCAN_BIT = 5;
  localparam int BUSY_BIT = 7;
  localparam int NRES = 16;
  localparam int CNT_W = 4;

  // ----------------------------------------
  // encodings
  // ----------------------------------------
  localparam logic [1:0] FREEZE_RUN = 2'h0;
  localparam logic [1:0] FREEZE_FINISH = 2'h2;
  localparam logic [1:0] FREEZE_NOW = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ISSUE = 2'b01,
    ST_WAIT = 2'b10
  } adcsrc_state_e;

endpackage : adcsrc_pkg

// File: verilog/adcsrc_top.sv
// sequence length, result placement, justification and freeze control
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module adcsrc_top #(
  parameter int RES_W = 12
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // converter core
  output logic conv_start,
  output logic conv_abort,
  output logic conv_freeze,
  input wire logic conv_done,
  input wire logic [RES_W-1:0] conv_data,
  // debugger
  input wire logic freeze_req,
  // compare enables
  input wire logic compare_irq_enable,
  input wire logic [15:0] per_result_compare_enable,
  output logic cmp_irq_en_out,
  output logic [15:0] cmp_en_out
);

  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  generate
    if (RES_W < 1 || RES_W > 16) begin : g_bad_width
      $error("RES_W must lie in 1..16");
    end
  endgenerate

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // word index of a byte address
  function automatic logic [5:0] word_idx(input logic [7:0] a);
    word_idx = a[7:2];
  endfunction : word_idx

  // length field to count; zero means the full file
  function automatic logic [4:0] seq_count(input logic [3:0] f);
    seq_count = (f == 4'h0) ? 5'h10 : {1'b0, f};
  endfunction : seq_count

  // place raw data into the 16-bit result word
  function automatic logic [15:0] justify(input logic right,
                                          input logic [RES_W-1:0] d);
    logic [15:0] w;
    w = 16'h0000;
    w[RES_W-1:0] = d;
    justify = right ? w : 16'(w << (16 - RES_W));
  endfunction : justify

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic wr_fire, wr_ok, rd_ok, ctl3_wr, start_wr, flags_wr, abort;
  logic [7:0] wr_addr, rd_addr, ctl3_reg;
  logic [31:0] wr_data, rd_data;
  logic [3:0] wr_strb, cnt;
  logic scan_reg, accept_done, last, hold, fifo;
  logic [15:0] flags_reg;
  logic [15:0] res_mem [adcsrc_pkg::NRES];
  logic [4:0] seq_idx_reg;
  adcsrc_pkg::adcsrc_state_e state_reg;
  logic [1:0] freeze_code;

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  adcsrc_axil_slave #(
    .ADDR_W(adcsrc_pkg::ADDR_W)
  ) adcsrc_axil_slave_i (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .wr_fire(wr_fire), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_strb(wr_strb), .wr_ok(wr_ok), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_ok(rd_ok)
  );

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  // writes to the result words or the status are refused
  assign wr_ok = word_idx(wr_addr) == adcsrc_pkg::CTL3_IDX ||
                 word_idx(wr_addr) == adcsrc_pkg::START_IDX ||
                 word_idx(wr_addr) == adcsrc_pkg::FLAGS_IDX;
  assign ctl3_wr = wr_fire && wr_strb[0] &&
                   word_idx(wr_addr) == adcsrc_pkg::CTL3_IDX;
  assign start_wr = wr_fire && wr_strb[0] &&
                    word_idx(wr_addr) == adcsrc_pkg::START_IDX;
  assign flags_wr = wr_fire && word_idx(wr_addr) == adcsrc_pkg::FLAGS_IDX;
  assign abort = ctl3_wr || start_wr;

  // control fields
  assign fifo = ctl3_reg[adcsrc_pkg::FIFO_BIT];
  assign freeze_code = ctl3_reg[adcsrc_pkg::FREEZE_LSB +: 2];

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  // sequence_result_control, byte lane 0 only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl3_reg <= adcsrc_pkg::CTL3_RST;
    end else if (ctl3_wr) begin
      ctl3_reg <= wr_data[7:0];
    end
  end

  // scan bit of sequence_start_control
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_reg <= 1'b0;
    end else if (start_wr) begin
      scan_reg <= wr_data[adcsrc_pkg::SCAN_BIT];
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // last conversion of the programmed length
  assign last = seq_idx_reg ==
    5'(seq_count(ctl3_reg[adcsrc_pkg::SEQ_LEN_LSB +: 4]) - 5'h01);

  // both freeze-stop codes keep the next conversion from starting
  assign hold = freeze_req &&
                (freeze_code == adcsrc_pkg::FREEZE_FINISH ||
                 freeze_code == adcsrc_pkg::FREEZE_NOW);

  // a result landing with an abort is dropped, abort wins
  assign accept_done = state_reg == adcsrc_pkg::ST_WAIT && conv_done &&
                       !abort;

  // state: any control write ends the running sequence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= adcsrc_pkg::ST_IDLE;
    end else if (ctl3_wr) begin
      state_reg <= adcsrc_pkg::ST_IDLE;
    end else if (start_wr) begin
      state_reg <= adcsrc_pkg::ST_ISSUE;
    end else begin
      case (state_reg)
        adcsrc_pkg::ST_ISSUE: begin
          if (!hold) begin
            state_reg <= adcsrc_pkg::ST_WAIT;
          end
        end
        adcsrc_pkg::ST_WAIT: begin
          if (conv_done) begin
            state_reg <= (last && !scan_reg) ? adcsrc_pkg::ST_IDLE :
                                               adcsrc_pkg::ST_ISSUE;
          end
        end
        default: begin
          state_reg <= adcsrc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // position within the sequence
  always_ff @(posedge aclk) begin
    if (!aresetn || abort) begin
      seq_idx_reg <= '0;
    end else if (accept_done) begin
      seq_idx_reg <= last ? 5'h00 : 5'(seq_idx_reg + 5'h01);
    end
  end

  // start pulse to the core, one per conversion
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_start <= 1'b0;
    end else begin
      conv_start <= !abort && !hold &&
                    state_reg == adcsrc_pkg::ST_ISSUE;
    end
  end

  // abort pulse only when something was running
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_abort <= 1'b0;
    end else begin
      conv_abort <= abort && state_reg != adcsrc_pkg::ST_IDLE;
    end
  end

  // immediate freeze pauses the core mid-conversion
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_freeze <= 1'b0;
    end else begin
      conv_freeze <= freeze_req && freeze_code == adcsrc_pkg::FREEZE_NOW &&
                     state_reg == adcsrc_pkg::ST_WAIT && !abort;
    end
  end

  // ----------------------------------------
  // result placement
  // ----------------------------------------

  // non-fifo returns to register 0 at each sequence end
  adcsrc_conv_counter #(
    .CNT_W(adcsrc_pkg::CNT_W)
  ) adcsrc_conv_counter_i (
    .aclk(aclk), .aresetn(aresetn), .clr(abort),
    .adv(accept_done), .seq_wrap(last && !fifo),
    .cnt(cnt)
  );

  // result file, no reset needed for data storage
  always_ff @(posedge aclk) begin
    if (accept_done) begin
      res_mem[cnt] <= justify(ctl3_reg[adcsrc_pkg::JUSTIFY_BIT],
                              conv_data);
    end
  end

  // complete flags: set beats a write-one clear in the same edge
  generate
    for (genvar i = 0; i < adcsrc_pkg::NRES; i++) begin : g_flag
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          flags_reg[i] <= 1'b0;
        end else if (accept_done && cnt == 4'(i)) begin
          flags_reg[i] <= 1'b1;
        end else if (start_wr) begin
          flags_reg[i] <= 1'b0;
        end else if (flags_wr && wr_strb[i/8] && wr_data[i]) begin
          flags_reg[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // compare gating
  // ----------------------------------------
  // fifo placement makes compare slots meaningless, so force off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_irq_en_out <= 1'b0;
      cmp_en_out <= 16'h0000;
    end else begin
      cmp_irq_en_out <= compare_irq_enable && !fifo;
      cmp_en_out <= fifo ? 16'h0000 : per_result_compare_enable;
    end
  end

  // ----------------------------------------
  // read decode
  // ----------------------------------------
  // reads have no side effects
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok = 1'b1;
    if (word_idx(rd_addr) >= adcsrc_pkg::RES_BASE_IDX &&
        word_idx(rd_addr) < adcsrc_pkg::RES_BASE_IDX + 6'h10) begin
      rd_data[15:0] = res_mem[rd_addr[5:2]];
    end else begin
      case (word_idx(rd_addr))
        adcsrc_pkg::CTL3_IDX: rd_data[7:0] = ctl3_reg;
        adcsrc_pkg::START_IDX: rd_data[adcsrc_pkg::SCAN_BIT] = scan_reg;
        adcsrc_pkg::STAT0_IDX: begin
          rd_data[3:0] = cnt;
          rd_data[adcsrc_pkg::BUSY_BIT] =
            state_reg != adcsrc_pkg::ST_IDLE;
        end
        adcsrc_pkg::FLAGS_IDX: rd_data[15:0] = flags_reg;
        default: rd_ok = 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_ABORT_IDLE:
    assert property (ctl3_wr |=> state_reg == adcsrc_pkg::ST_IDLE &&
                     !conv_start)
    else $error("control write did not abort the sequence");

  AST_JUSTIFY_RIGHT:
    assert property (accept_done && ctl3_reg[adcsrc_pkg::JUSTIFY_BIT]
                     |=> res_mem[$past(cnt)][RES_W-1:0] == $past(conv_data))
    else $error("right justified result misplaced");

  AST_SEQ_END:
    assert property (accept_done && last && !scan_reg && !fifo
                     |=> state_reg == adcsrc_pkg::ST_IDLE && cnt == 4'h0)
    else $error("sequence did not end at programmed length");

  AST_FIFO_STEP:
    assert property (accept_done && fifo
                     |=> cnt == 4'($past(cnt) + 4'h1))
    else $error("fifo counter did not step");

  AST_FIFO_WRAP:
    assert property (accept_done && fifo && cnt == 4'hF |=> cnt == 4'h0)
    else $error("fifo counter did not wrap");

  AST_START_CLEAR:
    assert property (start_wr |=> cnt == 4'h0 &&
                     state_reg == adcsrc_pkg::ST_ISSUE)
    else $error("start did not clear counter");

  AST_CMP_OFF:
    assert property (fifo && $stable(fifo) |=> !cmp_irq_en_out &&
                     cmp_en_out == 16'h0000)
    else $error("compare left enabled in fifo placement");

  AST_FREEZE_HOLD:
    assert property (state_reg == adcsrc_pkg::ST_ISSUE && hold && !abort
                     |=> !conv_start)
    else $error("conversion started during freeze");

  AST_FREEZE_NOW:
    assert property (freeze_req && !abort &&
                     freeze_code == adcsrc_pkg::FREEZE_NOW &&
                     state_reg == adcsrc_pkg::ST_WAIT |=> conv_freeze)
    else $error("immediate freeze not applied");

  AST_FLAG_SET:
    assert property (accept_done |=> flags_reg[$past(cnt)])
    else $error("complete flag not set");

  AST_LEN_ZERO:
    assert property (ctl3_reg[adcsrc_pkg::SEQ_LEN_LSB +: 4] == 4'h0 &&
                     seq_idx_reg == 5'h0F |-> last)
    else $error("zero length field is not sixteen");

endmodule : adcsrc_top
